/* File: verilog/rpwm_mapper.sv */
// Summary of operation
// - eight-bit page selector, software readable and writable
// - local 0x1000-0x1fff goes to selected page
// - selector resets to 0xfd, linear ram
// - local 0x2000-0x2fff always page 0xfe
// - local 0x3000-0x3fff always page 0xff
// - page 0x00 window reaches register space
// - unbacked part of page 0xfd is unimplemented
// - cpu and debug paths share the selector
module rpwm_mapper
    import rpwm_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [rpwm_pkg::REG_AW-1:0] awaddr,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [rpwm_pkg::REG_AW-1:0] araddr,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // cpu local access
    input wire logic cpu_req_valid,
    input wire logic [rpwm_pkg::LOCAL_AW-1:0] cpu_local_addr,
    output logic cpu_map_valid,
    output logic [rpwm_pkg::GLOBAL_AW-1:0] cpu_global_addr,
    output logic cpu_in_ram,
    output logic cpu_reg_alias,
    output logic cpu_unimpl,
    // debug local access
    input wire logic dbg_req_valid,
    input wire logic [rpwm_pkg::LOCAL_AW-1:0] dbg_local_addr,
    output logic dbg_map_valid,
    output logic [rpwm_pkg::GLOBAL_AW-1:0] dbg_global_addr,
    output logic dbg_in_ram,
    output logic dbg_reg_alias,
    output logic dbg_unimpl,
    // current selector
    output logic [rpwm_pkg::PAGE_W-1:0] ram_page_select
);
    import rpwm_pkg::*;

    logic [SIZE_W-1:0] implemented_ram_size;
    logic [CNT_W-1:0] unimpl_count;
    logic [CNT_W-1:0] alias_count;
    logic [GLOBAL_AW-1:0] cpu_last;
    logic [GLOBAL_AW-1:0] dbg_last;

    // write channel holding registers
    logic aw_held;
    logic w_held;
    logic [REG_AW-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;
    logic wr_page;
    logic wr_size;
    logic wr_clear;
    logic wr_known;
    logic [REG_AW-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    // read path
    logic [31:0] next_rdata;
    logic next_rmapped;

    // event counting
    logic [1:0] unimpl_events;
    logic [1:0] alias_events;
    logic clear_unimpl;
    logic clear_alias;

    // both masters may hit in one cycle, hence two event bits
    function automatic logic [CNT_W-1:0] rpwm_count(input logic [CNT_W-1:0] cur,
                                                    input logic clr,
                                                    input logic [1:0] ev);
        logic [CNT_W-1:0] base;
        logic [CNT_W-1:0] inc;
        base = clr ? '0 : cur;
        inc = {{(CNT_W-1){1'b0}}, ev[0]} + {{(CNT_W-1){1'b0}}, ev[1]};
        // saturate instead of wrapping so a busy system never reads as quiet
        if ((base + inc) < base) begin
            rpwm_count = '1;
        end else begin
            rpwm_count = base + inc;
        end
    endfunction

    // offsets that answer okay, for reads and writes alike
    function automatic logic rpwm_known_ofs(input logic [REG_AW-1:0] a);
        case (a)
            OFS_PAGE, OFS_RAM_SIZE, OFS_COUNTS, OFS_CPU_LAST, OFS_DBG_LAST, OFS_CLEAR: begin
                rpwm_known_ofs = 1'b1;
            end
            default: begin
                rpwm_known_ofs = 1'b0;
            end
        endcase
    endfunction

    // write channel: address and data may arrive in either order
    // a held half blocks its own channel until the write completes
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr_q <= '0;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (do_write) begin
            w_held <= 1'b0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end
    end

    // both halves present, now or from an earlier beat
    assign do_write = !bvalid && (aw_held || awvalid) && (w_held || wvalid);
    assign wr_addr = aw_held ? aw_addr_q : awaddr;
    assign wr_data = w_held ? w_data_q : wdata;
    assign wr_strb = w_held ? w_strb_q : wstrb;

    assign wr_page = do_write && (wr_addr == OFS_PAGE);
    assign wr_size = do_write && (wr_addr == OFS_RAM_SIZE);
    assign wr_clear = do_write && (wr_addr == OFS_CLEAR);
    assign wr_known = rpwm_known_ofs(wr_addr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_write) begin
            // no second write is taken while this answer waits
            bvalid <= 1'b1;
            // read-only registers accept and ignore writes; holes answer slverr
            bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ram_page_select <= PAGE_RESET;
        end else if (wr_page && wr_strb[0]) begin
            // a new page reaches requests sampled after this edge
            // writable any time
            ram_page_select <= wr_data[PAGE_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            implemented_ram_size <= RAM_SIZE_KB_RESET;
        end else if (wr_size) begin
            // only byte lanes 0 and 1 hold size bits
            if (wr_strb[0]) begin
                implemented_ram_size[7:0] <= wr_data[7:0];
            end
            if (wr_strb[1]) begin
                implemented_ram_size[SIZE_W-1:8] <= wr_data[SIZE_W-1:8];
            end
        end
    end

    // address translation for both masters
    // identical translators, so cpu and debug never disagree on a page
    // one selector, two paths
    rpwm_translate u_cpu_map (
        .aclk(aclk),
        .aresetn(aresetn),
        .page_sel(ram_page_select),
        .ram_size_kb(implemented_ram_size),
        .req_valid(cpu_req_valid),
        .local_addr(cpu_local_addr),
        .map_valid(cpu_map_valid),
        .global_addr(cpu_global_addr),
        .in_ram(cpu_in_ram),
        .reg_alias(cpu_reg_alias),
        .unimpl(cpu_unimpl)
    );

    rpwm_translate u_dbg_map (
        .aclk(aclk),
        .aresetn(aresetn),
        .page_sel(ram_page_select),
        .ram_size_kb(implemented_ram_size),
        .req_valid(dbg_req_valid),
        .local_addr(dbg_local_addr),
        .map_valid(dbg_map_valid),
        .global_addr(dbg_global_addr),
        .in_ram(dbg_in_ram),
        .reg_alias(dbg_reg_alias),
        .unimpl(dbg_unimpl)
    );

    // last translated address of each master, for software inspection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_last <= '0;
        end else if (cpu_map_valid) begin
            cpu_last <= cpu_global_addr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dbg_last <= '0;
        end else if (dbg_map_valid) begin
            dbg_last <= dbg_global_addr;
        end
    end

    // event counters; a hit in the clear cycle still counts
    // unimplemented and page-zero alias hits counted
    assign unimpl_events = {dbg_map_valid && dbg_unimpl, cpu_map_valid && cpu_unimpl};
    assign alias_events = {dbg_map_valid && dbg_reg_alias, cpu_map_valid && cpu_reg_alias};
    assign clear_unimpl = wr_clear && wr_strb[0] && wr_data[0];
    assign clear_alias = wr_clear && wr_strb[0] && wr_data[1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unimpl_count <= '0;
        end else begin
            unimpl_count <= rpwm_count(unimpl_count, clear_unimpl, unimpl_events);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alias_count <= '0;
        end else begin
            alias_count <= rpwm_count(alias_count, clear_alias, alias_events);
        end
    end

    // read channel
    // one read in flight; a new address waits for the rready edge
    assign arready = !rvalid;

    always_comb begin
        next_rdata = '0;
        // holes read as zero with an error response
        next_rmapped = rpwm_known_ofs(araddr);
        case (araddr)
            OFS_PAGE: next_rdata = {{(32-PAGE_W){1'b0}}, ram_page_select};
            OFS_RAM_SIZE: next_rdata = {{(32-SIZE_W){1'b0}}, implemented_ram_size};
            OFS_COUNTS: next_rdata = {alias_count, unimpl_count};
            OFS_CPU_LAST: next_rdata = {{(32-GLOBAL_AW){1'b0}}, cpu_last};
            OFS_DBG_LAST: next_rdata = {{(32-GLOBAL_AW){1'b0}}, dbg_last};
            // clear register is write-only and reads as zero
            OFS_CLEAR: next_rdata = '0;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            // data are frozen here and stand until the rready edge
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rmapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule // rpwm_mapper

/* File: pkg/rpwm_pkg.sv */
package rpwm_pkg;

    // local and global map geometry
    localparam int LOCAL_AW = 16;
    localparam int GLOBAL_AW = 23;
    localparam int PAGE_W = 8;
    localparam int OFF_W = 12;
    localparam int RAM_AW = PAGE_W + OFF_W;
    localparam int SIZE_W = 11;
    localparam int CNT_W = 16;
    localparam int REG_AW = 8;

    // local window boundaries, upper nibble of the local address
    localparam logic [3:0] NIB_WINDOW = 4'h1;
    localparam logic [3:0] NIB_FIXED_FE = 4'h2;
    localparam logic [3:0] NIB_FIXED_FF = 4'h3;

    // page numbers
    localparam logic [PAGE_W-1:0] PAGE_RESET = 8'hfd;
    localparam logic [PAGE_W-1:0] PAGE_FIXED_FE = 8'hfe;
    localparam logic [PAGE_W-1:0] PAGE_FIXED_FF = 8'hff;
    localparam logic [PAGE_W-1:0] PAGE_REG_SPACE = 8'h00;

    // ram occupies the top of the paged space, ending after page 0xff
    localparam logic [RAM_AW:0] RAM_TOP = 21'h100000;
    localparam logic [SIZE_W-1:0] RAM_SIZE_KB_RESET = 11'h00c;
    localparam int KB_SHIFT = 10;

    // register byte offsets
    localparam logic [REG_AW-1:0] OFS_PAGE = 8'h00;
    localparam logic [REG_AW-1:0] OFS_RAM_SIZE = 8'h04;
    localparam logic [REG_AW-1:0] OFS_COUNTS = 8'h08;
    localparam logic [REG_AW-1:0] OFS_CPU_LAST = 8'h0c;
    localparam logic [REG_AW-1:0] OFS_DBG_LAST = 8'h10;
    localparam logic [REG_AW-1:0] OFS_CLEAR = 8'h14;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RPWM_REGION_PASS,
        RPWM_REGION_WINDOW,
        RPWM_REGION_FIXED
    } rpwm_region_t;

    // page reached by a local address for a given selector
    function automatic logic [PAGE_W-1:0] rpwm_page_of(input logic [LOCAL_AW-1:0] la,
                                                       input logic [PAGE_W-1:0] sel);
        case (la[15:12])
            NIB_WINDOW: rpwm_page_of = sel;
            NIB_FIXED_FE: rpwm_page_of = PAGE_FIXED_FE;
            NIB_FIXED_FF: rpwm_page_of = PAGE_FIXED_FF;
            default: rpwm_page_of = PAGE_REG_SPACE;
        endcase
    endfunction

endpackage

/* File: verilog/rpwm_translate.sv */
module rpwm_translate
    import rpwm_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // settings
    input wire logic [rpwm_pkg::PAGE_W-1:0] page_sel,
    input wire logic [rpwm_pkg::SIZE_W-1:0] ram_size_kb,
    // local request
    input wire logic req_valid,
    input wire logic [rpwm_pkg::LOCAL_AW-1:0] local_addr,
    // translated result, one cycle later
    output logic map_valid,
    output logic [rpwm_pkg::GLOBAL_AW-1:0] global_addr,
    output logic in_ram,
    output logic reg_alias,
    output logic unimpl
);
    import rpwm_pkg::*;

    logic [PAGE_W-1:0] page;
    logic [RAM_AW-1:0] ram_addr;
    logic [RAM_AW:0] ram_start;
    logic is_window;
    logic is_ram;
    logic unbacked;

    assign is_window = (local_addr[15:12] == NIB_WINDOW);
    assign is_ram = is_window || (local_addr[15:12] == NIB_FIXED_FE) || (local_addr[15:12] == NIB_FIXED_FF);
    assign page = rpwm_page_of(local_addr, page_sel);
    assign ram_addr = {page, local_addr[OFF_W-1:0]};
    assign ram_start = RAM_TOP - ({{(RAM_AW+1-SIZE_W){1'b0}}, ram_size_kb} << KB_SHIFT);
    // 12 kb and up back all of page 0xfd; sizes above 1024 kb would wrap the start
    assign unbacked = (page == PAGE_RESET) && (ram_size_kb < RAM_SIZE_KB_RESET) && ({1'b0, ram_addr} < ram_start);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            map_valid <= 1'b0;
        end else begin
            map_valid <= req_valid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_addr <= '0;
            in_ram <= 1'b0;
            reg_alias <= 1'b0;
            unimpl <= 1'b0;
        end else if (req_valid) begin
            // outside the ram region the local address passes straight through
            global_addr <= is_ram ? {{(GLOBAL_AW-RAM_AW){1'b0}}, ram_addr}
                                  : {{(GLOBAL_AW-LOCAL_AW){1'b0}}, local_addr};
            unimpl <= is_ram && unbacked;
            in_ram <= is_ram && !unbacked && !(is_window && page == PAGE_REG_SPACE);
            reg_alias <= is_window && (page == PAGE_REG_SPACE);
        end
    end

endmodule // rpwm_translate

/* File: dv/rpwm_local_master.sv */
module rpwm_local_master
    import rpwm_pkg::*;
(
    // clock
    input wire logic aclk,
    // local request
    output logic req_valid,
    output logic [rpwm_pkg::LOCAL_AW-1:0] local_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req_valid = 1'b0;
        local_addr = '0;
    end

    // one request cycle; the address bus is scrambled once released
    task automatic issue(input logic [LOCAL_AW-1:0] a);
        @(posedge aclk);
        req_valid <= 1'b1;
        local_addr <= a;
        @(posedge aclk);
        req_valid <= 1'b0;
        local_addr <= ~a;
    endtask
endmodule // rpwm_local_master

/* File: dv/rpwm_mapper_assertions.sv */
module rpwm_mapper_assertions
    import rpwm_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register write
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [rpwm_pkg::REG_AW-1:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // cpu side
    input wire logic cpu_req_valid,
    input wire logic [rpwm_pkg::LOCAL_AW-1:0] cpu_local_addr,
    input wire logic cpu_map_valid,
    input wire logic [rpwm_pkg::GLOBAL_AW-1:0] cpu_global_addr,
    input wire logic cpu_in_ram,
    input wire logic cpu_reg_alias,
    input wire logic cpu_unimpl,
    // debug side
    input wire logic dbg_req_valid,
    input wire logic [rpwm_pkg::LOCAL_AW-1:0] dbg_local_addr,
    input wire logic dbg_map_valid,
    input wire logic [rpwm_pkg::GLOBAL_AW-1:0] dbg_global_addr,
    // selector
    input wire logic [rpwm_pkg::PAGE_W-1:0] ram_page_select
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_sel_write: assert property (awvalid && awready && wvalid && wready && awaddr == OFS_PAGE && wstrb[0]
        |=> ram_page_select == $past(wdata[7:0])) else $error("selector did not take written value");
    chk_reset_page: assert property ($rose(aresetn) |-> ram_page_select == PAGE_RESET)
        else $error("selector not 0xfd after reset");
    chk_win_page: assert property (cpu_req_valid && cpu_local_addr[15:12] == NIB_WINDOW |=> cpu_map_valid
        && cpu_global_addr == {3'h0, $past(ram_page_select), $past(cpu_local_addr[11:0])})
        else $error("cpu window address wrong");
    chk_fixed_fe: assert property (cpu_req_valid && cpu_local_addr[15:12] == NIB_FIXED_FE
        |=> cpu_global_addr[19:12] == PAGE_FIXED_FE && cpu_in_ram) else $error("fixed page fe wrong");
    chk_fixed_ff: assert property (dbg_req_valid && dbg_local_addr[15:12] == NIB_FIXED_FF
        |=> dbg_global_addr[22:12] == {3'h0, PAGE_FIXED_FF}) else $error("fixed page ff wrong");
    chk_alias_win: assert property (cpu_req_valid && cpu_local_addr[15:12] == NIB_WINDOW
        && ram_page_select == PAGE_REG_SPACE |=> cpu_reg_alias && !cpu_in_ram) else $error("page zero not aliased");
    chk_unimpl_page: assert property (cpu_map_valid && cpu_unimpl
        |-> !cpu_in_ram && cpu_global_addr[19:12] == PAGE_RESET) else $error("unimplemented flag misplaced");
    chk_dbg_window: assert property (dbg_req_valid && dbg_local_addr[15:12] == NIB_WINDOW |=> dbg_map_valid
        && dbg_global_addr == {3'h0, $past(ram_page_select), $past(dbg_local_addr[11:0])})
        else $error("debug window address wrong");

    cov_alias: cover property (cpu_map_valid && cpu_reg_alias);
    cov_unimpl: cover property (cpu_map_valid && cpu_unimpl);
    cov_dbg: cover property (dbg_map_valid);
endmodule // rpwm_mapper_assertions

bind rpwm_mapper rpwm_mapper_assertions u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .cpu_req_valid(cpu_req_valid), .cpu_local_addr(cpu_local_addr), .cpu_map_valid(cpu_map_valid),
    .cpu_global_addr(cpu_global_addr), .cpu_in_ram(cpu_in_ram), .cpu_reg_alias(cpu_reg_alias),
    .cpu_unimpl(cpu_unimpl), .dbg_req_valid(dbg_req_valid), .dbg_local_addr(dbg_local_addr),
    .dbg_map_valid(dbg_map_valid), .dbg_global_addr(dbg_global_addr), .ram_page_select(ram_page_select));

/* File: dv/rpwm_mapper_test.sv */
module rpwm_mapper_test;
    timeunit 1ns;
    timeprecision 1ps;
    import rpwm_pkg::*;

    logic aclk = 1'b0, aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic cpu_req_valid, cpu_map_valid, cpu_in_ram, cpu_reg_alias, cpu_unimpl;
    logic dbg_req_valid, dbg_map_valid, dbg_in_ram, dbg_reg_alias, dbg_unimpl;
    logic [15:0] cpu_local_addr, dbg_local_addr;
    logic [22:0] cpu_global_addr, dbg_global_addr;
    logic [7:0] ram_page_select;
    int fail_count = 0;
    int n_tests = 0;

    always #2.5 aclk = ~aclk;

    rpwm_local_master u_cpu (.aclk(aclk), .req_valid(cpu_req_valid), .local_addr(cpu_local_addr));
    rpwm_local_master u_dbg (.aclk(aclk), .req_valid(dbg_req_valid), .local_addr(dbg_local_addr));
    rpwm_mapper DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .cpu_req_valid(cpu_req_valid), .cpu_local_addr(cpu_local_addr),
        .cpu_map_valid(cpu_map_valid), .cpu_global_addr(cpu_global_addr), .cpu_in_ram(cpu_in_ram),
        .cpu_reg_alias(cpu_reg_alias), .cpu_unimpl(cpu_unimpl), .dbg_req_valid(dbg_req_valid),
        .dbg_local_addr(dbg_local_addr), .dbg_map_valid(dbg_map_valid), .dbg_global_addr(dbg_global_addr),
        .dbg_in_ram(dbg_in_ram), .dbg_reg_alias(dbg_reg_alias), .dbg_unimpl(dbg_unimpl),
        .ram_page_select(ram_page_select));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic timed_out(input string what);
        fail_count++;
        $display("mismatch %s expected answer seen none", what);
        end_of_test();
    endtask

    task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bready held from the start, so the answer is taken at the first bvalid edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int i;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        bready <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (i == 20) timed_out("write response");
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int i;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (i == 20) timed_out("read data");
    endtask

    task automatic reg_check(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        cmp_val("read data", exp, d);
        cmp_val("read resp", {30'h0, exp_resp}, {30'h0, r});
    endtask

    // flags are {in_ram, reg_alias, unimpl}
    task automatic map_check(input bit dbg, input logic [15:0] a, input logic [7:0] pg, input logic [2:0] fl);
        int i;
        if (dbg) u_dbg.issue(a);
        else u_cpu.issue(a);
        for (i = 0; i < 4; i++) begin
            #1;
            if ((dbg ? dbg_map_valid : cpu_map_valid) === 1'b1) break;
            @(posedge aclk);
        end
        if (i == 4) timed_out("map valid");
        cmp_val("global addr", {12'h0, pg, a[11:0]}, {9'h0, dbg ? dbg_global_addr : cpu_global_addr});
        cmp_val("flags", {29'h0, fl}, {29'h0, dbg ? {dbg_in_ram, dbg_reg_alias, dbg_unimpl}
            : {cpu_in_ram, cpu_reg_alias, cpu_unimpl}});
    endtask

    task automatic t_reset();
        reg_check(OFS_PAGE, 32'h0000_00fd, RESP_OKAY);
        reg_check(OFS_RAM_SIZE, 32'h0000_000c, RESP_OKAY);
        map_check(1'b0, 16'h1abc, 8'hfd, 3'b100);
        map_check(1'b0, 16'h2abc, 8'hfe, 3'b100);
        map_check(1'b1, 16'h3abc, 8'hff, 3'b100);
        map_check(1'b0, 16'hc0de, 8'h0c, 3'b000);
        map_check(1'b1, 16'h0123, 8'h00, 3'b000);
        $display("reset values done");
    endtask

    task automatic t_sweep();
        logic [7:0] pages [6] = '{8'h00, 8'h01, 8'h5a, 8'ha5, 8'hfe, 8'hff};
        logic [1:0] r;
        foreach (pages[k]) begin
            axi_write(OFS_PAGE, {24'h0, pages[k]}, r);
            reg_check(OFS_PAGE, {24'h0, pages[k]}, RESP_OKAY);
            map_check(1'b0, {4'h1, pages[k], 4'h7}, pages[k], (pages[k] == 8'h00) ? 3'b010 : 3'b100);
            map_check(1'b1, 16'h1fff, pages[k], (pages[k] == 8'h00) ? 3'b010 : 3'b100);
            map_check(1'b0, 16'h2000, 8'hfe, 3'b100);
            map_check(1'b1, 16'h3fff, 8'hff, 3'b100);
        end
        $display("page sweep done");
    endtask

    // 9 KB of ram starts at 0xfdc00, leaving the low 3 KB of page 0xfd empty
    task automatic t_unimpl();
        logic [1:0] r;
        axi_write(OFS_PAGE, 32'h0000_00fd, r);
        axi_write(OFS_RAM_SIZE, 32'h0000_0009, r);
        map_check(1'b0, 16'h1bff, 8'hfd, 3'b001);
        map_check(1'b0, 16'h1c00, 8'hfd, 3'b100);
        axi_write(OFS_RAM_SIZE, 32'h0000_000c, r);
        map_check(1'b0, 16'h1000, 8'hfd, 3'b100);
        $display("unimplemented region done");
    endtask

    task automatic t_unmapped();
        logic [1:0] r;
        axi_write(8'h18, 32'h0000_00aa, r);
        cmp_val("write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        reg_check(8'h18, 32'h0, RESP_SLVERR);
        reg_check(OFS_PAGE, 32'h0000_00fd, RESP_OKAY);
        $display("unmapped access done");
    endtask

    // so far: two page-zero window hits, one unbacked hit
    task automatic t_status();
        logic [1:0] r;
        reg_check(OFS_CPU_LAST, {12'h0, PAGE_RESET, 12'h000}, RESP_OKAY);
        reg_check(OFS_DBG_LAST, {12'h0, PAGE_FIXED_FF, 12'hfff}, RESP_OKAY);
        reg_check(OFS_COUNTS, 32'h0002_0001, RESP_OKAY);
        axi_write(OFS_CLEAR, 32'h0000_0003, r);
        cmp_val("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
        reg_check(OFS_COUNTS, 32'h0, RESP_OKAY);
        reg_check(OFS_CLEAR, 32'h0, RESP_OKAY);
        $display("status registers done");
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_sweep();
        t_unimpl();
        t_unmapped();
        t_status();
        end_of_test();
    end
endmodule // rpwm_mapper_test
